// ### hw/flash_wake_regs.svh
// constants for the wake and ident command logic
`ifndef FLASH_WAKE_REGS_SVH
`define FLASH_WAKE_REGS_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OP_WAKE_IDENT 8'hab
`define OP_DEEP_SLEEP 8'hb9
`define OP_PARAM_READ 8'h5a
`define OP_RST_ENABLE 8'h66
`define OP_RST_DO     8'h99

// ---------------------------------------------------------------
// frame layout, delivery state, timing
// ---------------------------------------------------------------
`define OPCODE_LAST_BIT 6'd7
`define DUMMY_LAST_BIT  6'd31
`define IDENT_FIRST_CNT 6'd32
`define STATUS_RESET    8'h00
`define ERASED_BYTE     8'hff
`define WIP_BIT         0
`define CLK_MHZ         125
`define T_WAKE_NS       3000
`define T_WAKE_ID_NS    8000
`define NS_TO_CYC(ns)   (((ns) * `CLK_MHZ + 999) / 1000)

`endif

// ### hw/flash_wake_pkg.sv
// types shared by the wake and ident command logic
package flash_wake_pkg;
  // events crossing from the serial clock side
  typedef struct packed {
    logic cs_n;   // select level
    logic cmd;    // toggles after each opcode
    logic ident;  // toggles after the third dummy byte
  } link_evt_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DELAY} wake_state_t;
endpackage

// ### hw/flash_wake_ident.sv
// wake from deep sleep and ident read command logic
`timescale 1ns/1ps
`include "flash_wake_regs.svh"
module flash_wake_ident import flash_wake_pkg::*; #(
  parameter logic [7:0] IDENT_BYTE  = 8'h5c,  // arbitrary value
  parameter int         WAKE_NS     = `T_WAKE_NS,
  parameter int         WAKE_ID_NS  = `T_WAKE_ID_NS,
  parameter int         DLY_W       = 16
) (
  input  wire  logic       CLOCK_I,     // system clock
  input  wire  logic       SYS_RST_I,   // async reset, high
  input  wire  logic       SCLK_I,      // serial clock
  input  wire  logic       CS_N_I,      // select, low active
  input  wire  logic       SI_I,        // serial data in
  input  wire  logic       WIP_I,       // write cycle busy
  output logic             SO_O,        // serial data out
  output logic             SO_EN_N_O,   // low while driving
  output logic             PD_O,        // deep sleep flag
  output logic             READY_O,     // commands accepted
  output logic [7:0]       STATUS_O,    // status byte
  output logic             CMD_VALID_O, // other opcode pulse
  output logic [7:0]       CMD_OP_O,    // its opcode
  output logic             SFDP_REQ_O,  // param read pulse
  output logic [7:0]       FILL_O       // erased byte value
);
  localparam int WAKE_CYC    = `NS_TO_CYC(WAKE_NS);
  localparam int WAKE_ID_CYC = `NS_TO_CYC(WAKE_ID_NS);
  localparam logic [DLY_W-1:0] WAKE_LD    = DLY_W'(WAKE_CYC - 1);
  localparam logic [DLY_W-1:0] WAKE_ID_LD = DLY_W'(WAKE_ID_CYC - 1);

  // ---------------------------------------------------------------
  // serial clock side
  // ---------------------------------------------------------------
  logic        link_rst;
  logic [5:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  op_link;
  logic        cmd_tgl;
  logic        id_tgl;
  logic        allow_m;
  logic        allow_s;
  logic [2:0]  out_idx;
  logic        id_allow;

  // select high ends the frame; sclk may be stopped then
  assign link_rst = CS_N_I | SYS_RST_I;

  // bit counter saturates once the ident phase is reached
  always_ff @(posedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt  <= 6'd0;
      shift_in <= 8'h00;
    end else begin
      shift_in <= {shift_in[6:0], SI_I};
      if (bit_cnt != `IDENT_FIRST_CNT)
        bit_cnt <= bit_cnt + 6'd1;
    end
  end

  // opcode and toggles survive select rising, so system side can read them
  always_ff @(posedge SCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      op_link <= 8'h00;
      cmd_tgl <= 1'b0;
      id_tgl  <= 1'b0;
    end else begin
      if (bit_cnt == `OPCODE_LAST_BIT) begin
        op_link <= {shift_in[6:0], SI_I};
        cmd_tgl <= ~cmd_tgl;
      end
      if (bit_cnt == `DUMMY_LAST_BIT && op_link == `OP_WAKE_IDENT)
        id_tgl <= ~id_tgl;
    end
  end

  // permission level from system side, two flops
  always_ff @(posedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      allow_m <= 1'b0;
      allow_s <= 1'b0;
    end else begin
      allow_m <= id_allow;
      allow_s <= allow_m;
    end
  end

  // ident bits change on falling edges, msb first, wrapping forever
  always_ff @(negedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      SO_O      <= 1'b0;
      SO_EN_N_O <= 1'b1;
      out_idx   <= 3'd0;
    end else if (bit_cnt == `IDENT_FIRST_CNT && op_link == `OP_WAKE_IDENT && allow_s) begin
      SO_O      <= IDENT_BYTE[3'd7 - out_idx];
      SO_EN_N_O <= 1'b0;
      out_idx   <= out_idx + 3'd1;
    end
  end

  // ---------------------------------------------------------------
  // crossing into the system clock
  // ---------------------------------------------------------------
  link_evt_t evt_raw;
  link_evt_t s1;
  link_evt_t s2;
  link_evt_t s3;
  link_evt_t filt;
  link_evt_t prev;

  assign evt_raw = '{cs_n: CS_N_I, cmd: cmd_tgl, ident: id_tgl};

  // three flops; a change counts once stages two and three agree
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        s1[g]   <= (g == 2);
        s2[g]   <= (g == 2);
        s3[g]   <= (g == 2);
        filt[g] <= (g == 2);
        prev[g] <= (g == 2);
      end else begin
        s1[g]   <= evt_raw[g];
        s2[g]   <= s1[g];
        s3[g]   <= s2[g];
        filt[g] <= (s2[g] == s3[g]) ? s3[g] : filt[g];
        prev[g] <= filt[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // system side command decisions
  // ---------------------------------------------------------------
  wake_state_t        st;
  logic [7:0]         op_sys;
  logic               long_frame;
  logic               rst_armed;
  logic [DLY_W-1:0]   dly;
  logic               cmd_ev;
  logic               id_ev;
  logic               frame_end;
  logic               is_wake;
  logic               do_sleep;
  logic               do_swrst;
  logic               pass_cmd;

  assign cmd_ev    = filt.cmd ^ prev.cmd;
  assign id_ev     = filt.ident ^ prev.ident;
  assign frame_end = (st == ST_FRAME) && filt.cs_n;
  assign is_wake   = frame_end && op_sys == `OP_WAKE_IDENT && !WIP_I;
  assign do_sleep  = frame_end && op_sys == `OP_DEEP_SLEEP && !WIP_I && !PD_O;
  assign do_swrst  = frame_end && op_sys == `OP_RST_DO && rst_armed;
  // deep sleep lets only wake and the reset pair through
  assign pass_cmd  = frame_end && !PD_O && op_sys != `OP_WAKE_IDENT
                     && op_sys != `OP_DEEP_SLEEP;

  // frame tracking and the wake delay counter
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st         <= ST_IDLE;
      op_sys     <= 8'h00;
      long_frame <= 1'b0;
      dly        <= '0;
    end else begin
      case (st)
        ST_IDLE: if (cmd_ev) begin
          st         <= ST_FRAME;
          op_sys     <= op_link; // stable until the next opcode
          long_frame <= 1'b0;
        end
        ST_FRAME: begin
          if (id_ev)
            long_frame <= 1'b1;
          if (filt.cs_n) begin
            st  <= (is_wake && PD_O) ? ST_DELAY : ST_IDLE;
            dly <= (long_frame || id_ev) ? WAKE_ID_LD : WAKE_LD;
          end
        end
        ST_DELAY: begin
          // frames here are dropped; host keeps select high anyway
          if (dly == '0)
            st <= ST_IDLE;
          dly <= dly - DLY_W'(1);
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // deep sleep flag, reset arming and registered outputs
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PD_O        <= 1'b0;
      rst_armed   <= 1'b0;
      READY_O     <= 1'b0;
      STATUS_O    <= `STATUS_RESET;
      CMD_VALID_O <= 1'b0;
      CMD_OP_O    <= 8'h00;
      SFDP_REQ_O  <= 1'b0;
      FILL_O      <= `ERASED_BYTE;
      id_allow    <= 1'b0;
    end else begin
      if (do_sleep)
        PD_O <= 1'b1;
      else if (do_swrst || (st == ST_DELAY && dly == '0))
        PD_O <= 1'b0;
      if (frame_end)
        rst_armed <= (op_sys == `OP_RST_ENABLE);
      READY_O     <= !PD_O && st != ST_DELAY;
      STATUS_O    <= {7'h00, WIP_I};
      CMD_VALID_O <= pass_cmd;
      CMD_OP_O    <= pass_cmd ? op_sys : CMD_OP_O;
      SFDP_REQ_O  <= pass_cmd && op_sys == `OP_PARAM_READ;
      id_allow    <= !WIP_I && st != ST_DELAY;
      FILL_O      <= `ERASED_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_wake_len;
    $rose(st == ST_DELAY) |-> dly == (long_frame ? WAKE_ID_LD : WAKE_LD);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake delay load wrong");

  property p_no_cmd_in_delay;
    $past(st == ST_DELAY) |-> !CMD_VALID_O && !SFDP_REQ_O;
  endproperty
  a_no_cmd_in_delay: assert property (p_no_cmd_in_delay) else $error("command during wake delay");

  property p_sleep_gate;
    CMD_VALID_O |-> !$past(PD_O);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("command passed in deep sleep");

  property p_busy_drop;
    frame_end && op_sys == `OP_WAKE_IDENT && WIP_I |=> $stable(PD_O) && st == ST_IDLE;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("wake taken while busy");

  property p_wip_bit;
    ##1 STATUS_O == {7'h00, $past(WIP_I)};
  endproperty
  a_wip_bit: assert property (p_wip_bit) else $error("status wip bit wrong");

  property p_param_read;
    SFDP_REQ_O |-> CMD_VALID_O && CMD_OP_O == `OP_PARAM_READ;
  endproperty
  a_param_read: assert property (p_param_read) else $error("param read misdecoded");

  property p_wake_clears;
    st == ST_DELAY && dly == '0 |=> !PD_O ##1 READY_O;
  endproperty
  a_wake_clears: assert property (p_wake_clears) else $error("sleep flag not cleared");

  property p_sleep_sets;
    do_sleep |=> PD_O ##1 !READY_O;
  endproperty
  a_sleep_sets: assert property (p_sleep_sets) else $error("sleep flag not set");

  property p_fill;
    FILL_O == `ERASED_BYTE && STATUS_O[7:1] == 7'h00;
  endproperty
  a_fill: assert property (p_fill) else $error("delivery state wrong");

  property p_msb_first;
    @(negedge SCLK_I) disable iff (link_rst)
      $fell(SO_EN_N_O) |-> SO_O == IDENT_BYTE[7] && out_idx == 3'd1;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("ident not msb first");
endmodule // flash_wake_ident

// ### tb/spi_host_model.sv
// spi host model: frames commands and captures the serial output
`timescale 1ns/1ps
module spi_host_model (
  output logic       sclk_o,    // serial clock, idle low
  output logic       cs_n_o,    // select, low active
  output logic       si_o,      // serial data to device
  input  wire  logic so_i,      // serial data from device
  input  wire  logic so_en_n_i  // low while device drives
);
  logic drove; // device drove its output in the last frame

  // idle bus; the clock stands still outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
    drove  = 1'b0;
  end

  // one frame; the gap comes first so a wake delay is timed from return
  task automatic xfer(input logic [7:0] op, input int ndum, input int nrd, output logic [15:0] rd);
    int n;
    n = 8 + 8 * ndum + nrd;
    rd = 16'h0000;
    drove = 1'b0;
    #100 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      // opcode msb first, zero dummies, then a toggling released line
      #8 si_o = (i < 8) ? op[7 - i] : ((i < 8 + 8 * ndum) ? 1'b0 : ~si_o);
      #7 sclk_o = 1'b1;
      if (i >= n - nrd) rd = {rd[14:0], so_i};
      if (so_en_n_i === 1'b0) drove = 1'b1;
      #15 sclk_o = 1'b0;
    end
    #8 cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule // spi_host_model

// ### tb/tb_flash_wake_and_id_read.sv
// self-checking bench for the wake and ident command logic
`timescale 1ns/1ps
module tb_flash_wake_and_id_read;
  import flash_wake_pkg::*;
  localparam logic [7:0] ID      = 8'h5c; // arbitrary value
  localparam int         WAKE    = 10;    // 80 ns at 8 ns
  localparam int         WAKE_ID = 20;    // 160 ns at 8 ns
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       write_in_progress = 1'b0;
  wire  logic sclk, cs_n, si, so, so_en_n, pd, ready, cmd_valid, sfdp_req;
  wire  logic [7:0] status, cmd_op, fill;
  logic [15:0] rd;
  logic [7:0]  seen_op;
  logic        seen_sfdp;
  int          seen_cnt = 0;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          c;

  always #4 clock = ~clock;

  flash_wake_ident #(.IDENT_BYTE(ID), .WAKE_NS(80), .WAKE_ID_NS(160)) flash_wake_ident_i (
    .CLOCK_I(clock), .SYS_RST_I(sys_rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si), .WIP_I(write_in_progress),
    .SO_O(so), .SO_EN_N_O(so_en_n), .PD_O(pd), .READY_O(ready), .STATUS_O(status),
    .CMD_VALID_O(cmd_valid), .CMD_OP_O(cmd_op), .SFDP_REQ_O(sfdp_req), .FILL_O(fill));

  spi_host_model spi_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_en_n_i(so_en_n));

  // one-cycle command pulses are caught in their own cycle
  always @(posedge clock) begin
    cycles++;
    if (cmd_valid === 1'b1) begin
      seen_cnt++;
      seen_op = cmd_op;
      seen_sfdp = sfdp_req;
    end
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // counts cycles from select rise until commands are accepted again
  task automatic count_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("status", 16'h0000, status);
    chk("fill", 16'h00ff, fill);
    chk("pd", 16'h0000, pd);
    chk("so_en_n", 16'h0001, so_en_n);
    $display("test reset done");
  endtask

  // awake ident read: two whole bytes, repeated, msb first
  task automatic t_ident();
    spi_host_model_i.xfer(8'hab, 3, 16, rd);
    chk("ident", {ID, ID}, rd);
    chk("drove", 16'h0001, spi_host_model_i.drove);
    wait_cyc(2);
    chk("released", 16'h0001, so_en_n);
    $display("test ident done");
  endtask

  task automatic t_param();
    seen_cnt = 0;
    spi_host_model_i.xfer(8'h5a, 0, 0, rd);
    wait_cyc(12);
    chk("param count", 16'h0001, seen_cnt[15:0]);
    chk("param op", 16'h005a, seen_op);
    chk("param req", 16'h0001, seen_sfdp);
    $display("test param done");
  endtask

  // sleep ignores other opcodes; wake-only needs the short delay
  task automatic t_sleep_wake();
    spi_host_model_i.xfer(8'hb9, 0, 0, rd);
    wait_cyc(8);
    chk("pd set", 16'h0001, pd);
    seen_cnt = 0;
    spi_host_model_i.xfer(8'h5a, 0, 0, rd);
    wait_cyc(12);
    chk("sleep drop", 16'h0000, seen_cnt[15:0]);
    spi_host_model_i.xfer(8'hab, 0, 0, rd);
    count_ready(c);
    chk("wake min", 16'h0001, c >= WAKE);
    chk("wake max", 16'h0001, c <= WAKE + 12);
    chk("pd clear", 16'h0000, pd);
    $display("test sleep_wake done");
  endtask

  task automatic t_wake_ident();
    spi_host_model_i.xfer(8'hb9, 0, 0, rd);
    wait_cyc(8);
    spi_host_model_i.xfer(8'hab, 3, 8, rd);
    chk("wake ident", {8'h00, ID}, rd);
    count_ready(c);
    chk("wake id min", 16'h0001, c >= WAKE_ID);
    chk("wake id max", 16'h0001, c <= WAKE_ID + 12);
    $display("test wake_ident done");
  endtask

  // busy write cycle: command dropped, status shows busy
  task automatic t_busy();
    @(posedge clock) write_in_progress <= 1'b1;
    wait_cyc(3);
    chk("status busy", 16'h0001, status);
    spi_host_model_i.xfer(8'hab, 3, 8, rd);
    chk("busy drove", 16'h0000, spi_host_model_i.drove);
    @(posedge clock) write_in_progress <= 1'b0;
    wait_cyc(3);
    chk("status idle", 16'h0000, status);
    $display("test busy done");
  endtask

  // the reset pair is the other way out of deep sleep; enable alone does nothing
  task automatic t_swreset();
    spi_host_model_i.xfer(8'hb9, 0, 0, rd);
    wait_cyc(8);
    chk("swrst pd set", 16'h0001, pd);
    spi_host_model_i.xfer(8'h66, 0, 0, rd);
    wait_cyc(8);
    chk("swrst armed pd", 16'h0001, pd);
    spi_host_model_i.xfer(8'h99, 0, 0, rd);
    wait_cyc(8);
    chk("swrst pd clear", 16'h0000, pd);
    chk("swrst ready", 16'h0001, ready);
    $display("test swreset done");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    wait_cyc(10);
    t_reset();
    t_ident();
    t_param();
    t_sleep_wake();
    t_wake_ident();
    t_busy();
    t_swreset();
    tally_and_finish();
  end
endmodule // tb_flash_wake_and_id_read
